//--- verilog/rxfe_pkg.sv
// Constants for the receive setup and frame event block
package rxfe_pkg;
  localparam logic [15:0] RXFE_ADDR_SETUP = 16'h0102;
  localparam logic [15:0] RXFE_ADDR_EVENT = 16'h0124;
  localparam logic [15:0] RXFE_ADDR_QUEUE = 16'h0120;
  localparam logic [15:0] RXFE_ADDR_STATUS = 16'h0400;
  localparam logic [15:0] RXFE_ADDR_LEN = 16'h0402;
  localparam logic [5:0] RXFE_ID_SETUP = 6'h03;
  localparam logic [5:0] RXFE_ID_EVENT = 6'h04;
  localparam logic [15:0] RXFE_SETUP_RST = 16'h0003;
  localparam logic [15:0] RXFE_EVENT_RST = 16'h0004;
  // Setup bit positions
  localparam int RXFE_B_SKIP = 6;
  localparam int RXFE_B_STREAM = 7;
  localparam int RXFE_B_GOOD_IE = 8;
  localparam int RXFE_B_DMA_ALWAYS = 9;
  localparam int RXFE_B_DMA_AUTO = 10;
  localparam int RXFE_B_KEEP_FCS = 11;
  localparam int RXFE_B_FCS_IE = 12;
  localparam int RXFE_B_SHORT_IE = 13;
  localparam int RXFE_B_LONG_IE = 14;
  // Event bit positions
  localparam int RXFE_E_IHASH = 6;
  localparam int RXFE_E_DRIBBLE = 7;
  localparam int RXFE_E_GOOD = 8;
  localparam int RXFE_E_HASHED = 9;
  localparam int RXFE_E_OWN = 10;
  localparam int RXFE_E_BCAST = 11;
  localparam int RXFE_E_FCS = 12;
  localparam int RXFE_E_SHORT = 13;
  localparam int RXFE_E_LONG = 14;
  // Frame length limits in bytes
  localparam logic [10:0] RXFE_MIN_LEN = 11'd64;
  localparam logic [10:0] RXFE_MAX_LEN = 11'd1518;
  localparam logic [10:0] RXFE_TINY_LEN = 11'd8;
  localparam logic [10:0] RXFE_FCS_LEN = 11'd4;
  localparam logic [2:0] RXFE_HOLD = 3'd4;
  localparam int RXFE_FIFO_DEPTH = 4;
endpackage

//--- verilog/rxfe_fifo.sv
// Shift-register FIFO; head entry and flags are flip-flops
`timescale 1ns/1ps
module rxfe_fifo #(
  parameter int W = 8,
  parameter int D = 4
) (
  input wire logic ref_clk, // Clock
  input wire logic sys_rst, // Async reset
  input wire logic in_valid, // Write request
  output logic in_ready, // Not full
  input wire logic [W-1:0] in_data, // Write data
  output logic out_valid, // Not empty
  input wire logic out_ready, // Drain accepts
  output logic [W-1:0] out_data // Head entry
);
  logic [W-1:0] mem [D];
  logic [$clog2(D+1)-1:0] cnt;
  logic [$clog2(D+1)-1:0] next_cnt;
  logic push;
  logic pop;

  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign out_data = mem[0];

  always_comb begin
    next_cnt = cnt;
    if (push & ~pop) begin
      next_cnt = cnt + 1'b1;
    end else if (pop & ~push) begin
      next_cnt = cnt - 1'b1;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt <= '0;
      in_ready <= 1'b1;
      out_valid <= 1'b0;
    end else begin
      cnt <= next_cnt;
      in_ready <= (next_cnt != D[$clog2(D+1)-1:0]);
      out_valid <= (next_cnt != '0);
    end
  end

  // Entry i takes the pushed word, its upper neighbour, or holds
  for (genvar i = 0; i < D; i++) begin : g_ent
    always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
        mem[i] <= '0;
      end else if (push &&
          i == int'(pop ? cnt - 1'b1 : cnt)) begin
        mem[i] <= in_data;
      end else if (pop) begin
        mem[i] <= (i == D - 1) ? '0 : mem[(i + 1) % D];
      end
    end
  end
endmodule

//--- verilog/rxfe_classify.sv
// Builds the frame event word from the frame's outcome
`timescale 1ns/1ps
module rxfe_classify
  import rxfe_pkg::*;
(
  input wire logic [10:0] byte_cnt, // Bytes on the wire
  input wire logic fcs_bad, // Check sequence failed
  input wire logic dribble, // Trailing bits seen
  input wire logic da_own, // Station address match
  input wire logic da_bcast, // All-ones destination
  input wire logic hashed, // Hash filter hit
  input wire logic [5:0] hash_index, // Hash table index
  input wire logic accept_own_address, // Filter control
  input wire logic accept_all_ones_address, // Filter control
  input wire logic accept_individual_hash, // Filter control
  output logic [15:0] word // Event word
);
  logic is_short;
  logic is_long;
  logic good;

  assign is_short = byte_cnt < RXFE_MIN_LEN;
  assign is_long = byte_cnt > RXFE_MAX_LEN;
  assign good = ~fcs_bad & ~is_short & ~is_long;

  always_comb begin
    word = 16'h0000;
    word[5:0] = RXFE_ID_EVENT;
    word[RXFE_E_IHASH] = good & accept_individual_hash & hashed;
    word[RXFE_E_DRIBBLE] = dribble;
    word[RXFE_E_GOOD] = good;
    word[RXFE_E_HASHED] = hashed;
    if (hashed & good) begin
      word[15:10] = hash_index;
    end else begin
      word[RXFE_E_OWN] = da_own & good & accept_own_address;
      word[RXFE_E_BCAST] = da_bcast & good & accept_all_ones_address;
      word[RXFE_E_FCS] = fcs_bad;
      word[RXFE_E_SHORT] = is_short;
      word[RXFE_E_LONG] = is_long;
    end
  end
endmodule

//--- verilog/rxfe_top.sv
// Receive setup register, frame event reporting and data path
//
// Contract
// - Discard bit drops last frame, once
// - Stream enable, with DMA-always or auto switch set, streams back-to-back passing frames
// - Good-frame enable raises interrupt
// - DMA-always forces DMA, overrides auto switch
// - Keep-FCS stores and counts check bytes
// - FCS-error enable raises interrupt
// - Short-frame enable raises interrupt
// - Frames under eight bytes always dropped
// - Long-frame enable interrupts, any FCS
// - Setup resets to identifier or EEPROM preset
// - Event reads carry identifier 000100
// - Event read clears; status copy persists
// - Hash event needs good, accept, hit
// - Trailing bits flag; with FCS, alignment
// - Good flag means no errors; length kept
// - Hash index in high bits when hashed, good
// - Own match needs good and accept
// - Broadcast needs good and accept
// - Error flags reported; bytes past maximum dropped
// - Enabled event loads queue word, raises request
`timescale 1ns/1ps
module rxfe_top
  import rxfe_pkg::*;
#(
  parameter int FIFO_DEPTH = RXFE_FIFO_DEPTH
) (
  input wire logic ref_clk, // System clock
  input wire logic sys_rst, // Async reset, active high
  input wire logic [15:0] hp_addr, // Host register address
  input wire logic [15:0] hp_wdata, // Host write data
  input wire logic hp_wr, // Host write strobe
  input wire logic hp_rd, // Host read strobe
  output logic [15:0] hp_rdata, // Read data, next cycle
  output logic irq, // Interrupt request
  input wire logic eeprom_present, // Configuration EEPROM found
  input wire logic [15:0] eeprom_setup, // EEPROM setup word
  input wire logic rx_valid, // Received byte valid
  output logic rx_ready, // Byte accepted
  input wire logic [7:0] rx_data, // Received byte
  input wire logic rx_last, // Final byte of frame
  input wire logic rx_fcs_bad, // At last: bad check sequence
  input wire logic rx_dribble, // At last: trailing bits
  input wire logic da_own, // At last: station match
  input wire logic da_bcast, // At last: all-ones address
  input wire logic da_hashed, // At last: hash hit
  input wire logic [5:0] da_hash_index, // At last: hash index
  input wire logic da_pass, // Frame passes address filter
  input wire logic back_to_back, // Frame follows previous closely
  input wire logic auto_switch_cond, // Auto DMA switch condition
  input wire logic accept_own_address, // Filter control
  input wire logic accept_all_ones_address, // Filter control
  input wire logic accept_individual_hash, // Filter control
  output logic buf_valid, // Buffer byte valid
  input wire logic buf_ready, // Buffer takes byte
  output logic [7:0] buf_data, // Buffer byte
  output logic frame_commit, // Pulse: stored frame complete
  output logic frame_drop, // Pulse: drop frame in progress
  output logic discard_last, // Pulse: delete last committed
  output logic dma_mode, // Frame goes by receive DMA
  output logic stream_mode // Streaming transfer active
);
  logic [15:0] setup;
  logic [15:0] events;
  logic [15:0] status_copy;
  logic [15:0] queue_word;
  logic [15:0] frame_len;
  logic preset_done;
  logic [10:0] byte_cnt;
  logic [10:0] next_cnt;
  logic [10:0] stored;
  logic [7:0] hold [4];
  logic [2:0] held;
  logic keep_fcs;
  logic in_frame;
  logic take;
  logic fin;
  logic push;
  logic [7:0] push_data;
  logic fifo_ready;
  logic [15:0] ev_word;
  logic ev_irq;
  logic rd_event;
  logic rd_queue;
  logic setup_wr;

  assign take = rx_valid & rx_ready;
  assign fin = take & rx_last;
  assign next_cnt = (byte_cnt == 11'h7ff) ? byte_cnt : byte_cnt + 11'd1;
  assign rd_event = hp_rd && hp_addr == RXFE_ADDR_EVENT;
  assign rd_queue = hp_rd && hp_addr == RXFE_ADDR_QUEUE;
  assign setup_wr = hp_wr && hp_addr == RXFE_ADDR_SETUP &&
                    hp_wdata[5:0] == RXFE_ID_SETUP;
  assign rx_ready = fifo_ready;

  // Setup register; the discard bit is never stored
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      setup <= RXFE_SETUP_RST;
      preset_done <= 1'b0;
    end else if (!preset_done) begin
      preset_done <= 1'b1;
      if (eeprom_present) begin
        setup <= {eeprom_setup[15:7], 1'b0, RXFE_ID_SETUP};
      end
    end else if (setup_wr) begin
      setup <= {1'b0, hp_wdata[14:7], 1'b0, RXFE_ID_SETUP};
    end
  end

  // One pulse per written one; rewriting is needed to drop another
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      discard_last <= 1'b0;
    end else begin
      discard_last <= setup_wr & hp_wdata[RXFE_B_SKIP];
    end
  end

  // DMA-always wins; auto switch looked at only otherwise
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      dma_mode <= 1'b0;
      stream_mode <= 1'b0;
    end else begin
      dma_mode <= setup[RXFE_B_DMA_ALWAYS] |
                  (setup[RXFE_B_DMA_AUTO] & auto_switch_cond);
      stream_mode <= setup[RXFE_B_STREAM] & back_to_back & da_pass &
                     (setup[RXFE_B_DMA_ALWAYS] |
                      setup[RXFE_B_DMA_AUTO]);
    end
  end

  // Frame byte counting; FCS mode latched at the first byte
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      byte_cnt <= '0;
      stored <= '0;
      in_frame <= 1'b0;
      keep_fcs <= 1'b0;
    end else if (fin) begin
      byte_cnt <= '0;
      stored <= '0;
      in_frame <= 1'b0;
    end else if (take) begin
      byte_cnt <= next_cnt;
      in_frame <= 1'b1;
      if (push) begin
        stored <= stored + 11'd1;
      end
      if (!in_frame) begin
        keep_fcs <= setup[RXFE_B_KEEP_FCS];
      end
    end
  end

  // Without FCS kept, a four byte lag hides the check bytes
  always_comb begin
    if (in_frame ? keep_fcs : setup[RXFE_B_KEEP_FCS]) begin
      push_data = rx_data;
      push = take;
    end else begin
      push_data = hold[3];
      push = take & (held == RXFE_HOLD);
    end
    if (stored >= RXFE_MAX_LEN) begin
      push = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      held <= '0;
      hold[0] <= '0;
      hold[1] <= '0;
      hold[2] <= '0;
      hold[3] <= '0;
    end else if (fin) begin
      held <= '0;
    end else if (take) begin
      hold[0] <= rx_data;
      hold[1] <= hold[0];
      hold[2] <= hold[1];
      hold[3] <= hold[2];
      if (held != RXFE_HOLD) begin
        held <= held + 3'd1;
      end
    end
  end

  rxfe_fifo #(
    .W(8),
    .D(FIFO_DEPTH)
  ) u_fifo (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .in_valid(push),
    .in_ready(fifo_ready),
    .in_data(push_data),
    .out_valid(buf_valid),
    .out_ready(buf_ready),
    .out_data(buf_data)
  );

  rxfe_classify u_cls (
    .byte_cnt(next_cnt),
    .fcs_bad(rx_fcs_bad),
    .dribble(rx_dribble),
    .da_own(da_own),
    .da_bcast(da_bcast),
    .hashed(da_hashed),
    .hash_index(da_hash_index),
    .accept_own_address(accept_own_address),
    .accept_all_ones_address(accept_all_ones_address),
    .accept_individual_hash(accept_individual_hash),
    .word(ev_word)
  );

  // Error bits carry the hash index on good hashed frames
  assign ev_irq = (ev_word[RXFE_E_GOOD] & setup[RXFE_B_GOOD_IE]) |
                  (~ev_word[RXFE_E_GOOD] & (
                  (ev_word[RXFE_E_FCS] & setup[RXFE_B_FCS_IE]) |
                  (ev_word[RXFE_E_SHORT] & setup[RXFE_B_SHORT_IE]) |
                  (ev_word[RXFE_E_LONG] & setup[RXFE_B_LONG_IE])));

  // Tiny frames vanish with no report at all
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      frame_commit <= 1'b0;
      frame_drop <= 1'b0;
    end else begin
      frame_commit <= fin && next_cnt >= RXFE_TINY_LEN;
      frame_drop <= fin && next_cnt < RXFE_TINY_LEN;
    end
  end

  // Length counts bytes actually stored in the buffer
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      frame_len <= '0;
    end else if (fin && next_cnt >= RXFE_TINY_LEN &&
                 ev_word[RXFE_E_GOOD]) begin
      frame_len <= {5'h00, keep_fcs ? next_cnt
                                    : next_cnt - RXFE_FCS_LEN};
    end
  end

  // New frame beats a same-cycle read, so no event is lost
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      events <= RXFE_EVENT_RST;
      status_copy <= RXFE_EVENT_RST;
    end else if (fin && next_cnt >= RXFE_TINY_LEN) begin
      events <= ev_word;
      status_copy <= ev_word;
    end else if (rd_event) begin
      events <= RXFE_EVENT_RST;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      queue_word <= '0;
      irq <= 1'b0;
    end else if (fin && next_cnt >= RXFE_TINY_LEN && ev_irq) begin
      queue_word <= ev_word;
      irq <= 1'b1;
    end else if (rd_queue) begin
      queue_word <= '0;
      irq <= 1'b0;
    end
  end

  // Register reads; unmapped addresses return zero
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      hp_rdata <= '0;
    end else if (hp_rd) begin
      if (hp_addr == RXFE_ADDR_SETUP) begin
        hp_rdata <= setup;
      end else if (hp_addr == RXFE_ADDR_EVENT) begin
        hp_rdata <= events;
      end else if (hp_addr == RXFE_ADDR_STATUS) begin
        hp_rdata <= status_copy;
      end else if (hp_addr == RXFE_ADDR_QUEUE) begin
        hp_rdata <= queue_word;
      end else if (hp_addr == RXFE_ADDR_LEN) begin
        hp_rdata <= frame_len;
      end else begin
        hp_rdata <= '0;
      end
    end
  end
endmodule

//--- bench/rxfe_top_sva.sv
// Assertions for the receive setup and frame event block
`timescale 1ns/1ps
module rxfe_top_sva
  import rxfe_pkg::*;
#(
  parameter int FIFO_DEPTH = RXFE_FIFO_DEPTH
) (
  input wire logic ref_clk, // Clock
  input wire logic sys_rst, // Reset
  input wire logic [15:0] hp_addr, // Address
  input wire logic [15:0] hp_wdata, // Write data
  input wire logic hp_wr, // Write
  input wire logic hp_rd, // Read
  input wire logic [15:0] hp_rdata, // Read data
  input wire logic irq, // Interrupt
  input wire logic eeprom_present, // EEPROM found
  input wire logic [15:0] eeprom_setup, // EEPROM word
  input wire logic rx_valid, // Byte valid
  input wire logic rx_ready, // Byte taken
  input wire logic rx_last, // Last byte
  input wire logic rx_fcs_bad, // Bad check
  input wire logic back_to_back, // Close frames
  input wire logic da_pass, // Filter pass
  input wire logic auto_switch_cond, // Switch condition
  input wire logic frame_commit, // Commit
  input wire logic frame_drop, // Drop
  input wire logic discard_last, // Discard
  input wire logic dma_mode, // DMA
  input wire logic stream_mode // Stream
);
  logic first;
  logic [15:0] cfg;
  logic [10:0] cnt;
  wire logic fend = rx_valid && rx_ready && rx_last;
  wire logic [10:0] nb = cnt + 11'd1;
  wire logic cfg_wr = hp_wr && hp_addr == RXFE_ADDR_SETUP;
  wire logic id_ok = hp_wdata[5:0] == RXFE_ID_SETUP;
  wire logic dma_on = cfg[RXFE_B_DMA_ALWAYS] || cfg[RXFE_B_DMA_AUTO];
  wire logic dma_cond = cfg[RXFE_B_DMA_ALWAYS] ||
    (cfg[RXFE_B_DMA_AUTO] && auto_switch_cond);
  wire logic strm_cond = cfg[RXFE_B_STREAM] && back_to_back && da_pass &&
    dma_on;
  // Shadow of the setup word, rebuilt from the EEPROM preset and accepted writes
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      first <= 1'b1;
      cfg <= RXFE_SETUP_RST;
    end else begin
      first <= 1'b0;
      if (first && eeprom_present)
        cfg <= {eeprom_setup[15:7], 1'b0, RXFE_ID_SETUP};
      else if (cfg_wr && id_ok)
        cfg <= hp_wdata;
    end
  end
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst)
      cnt <= 11'd0;
    else if (fend)
      cnt <= 11'd0;
    else if (rx_valid && rx_ready)
      cnt <= nb;
  end
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);
  sequence s_ev_rd;
    hp_rd && hp_addr == RXFE_ADDR_EVENT && !fend;
  endsequence
  sequence s_tiny_end;
    fend && nb < RXFE_TINY_LEN;
  endsequence
  sequence s_kept_end;
    fend && nb >= RXFE_TINY_LEN;
  endsequence
  a_skip_once: assert property (
    cfg_wr && id_ok && hp_wdata[RXFE_B_SKIP] |=>
    discard_last ##1 !discard_last)
    else $error("discard pulse wrong");
  a_bad_id_ignored: assert property (
    cfg_wr && !id_ok |=> !discard_last)
    else $error("write with wrong code acted");
  a_dma_select: assert property (
    !first |-> dma_mode == $past(dma_cond))
    else $error("dma mode wrong");
  a_stream_gate: assert property (
    !first |-> stream_mode == $past(strm_cond))
    else $error("stream mode wrong");
  a_tiny_drop: assert property (
    s_tiny_end |=> frame_drop && !frame_commit)
    else $error("tiny frame not dropped");
  a_frame_kept: assert property (
    s_kept_end |=> frame_commit && !frame_drop)
    else $error("frame not committed");
  a_event_code: assert property (
    hp_rd && hp_addr == RXFE_ADDR_EVENT |=> hp_rdata[5:0] == RXFE_ID_EVENT)
    else $error("event code wrong");
  a_read_clears: assert property (
    s_ev_rd ##1 !fend ##1 s_ev_rd |=> hp_rdata == RXFE_EVENT_RST)
    else $error("event read did not clear");
  a_good_irq: assert property (s_kept_end ##0 (nb >= RXFE_MIN_LEN &&
    nb <= RXFE_MAX_LEN && !rx_fcs_bad && cfg[RXFE_B_GOOD_IE]) |=> irq)
    else $error("good frame irq missing");
  a_fcs_irq: assert property (
    s_kept_end ##0 (rx_fcs_bad && cfg[RXFE_B_FCS_IE]) |=> irq)
    else $error("check error irq missing");
  a_tiny_quiet: assert property (
    fend && nb < RXFE_TINY_LEN && !irq |=> !irq)
    else $error("tiny frame raised irq");
endmodule
bind rxfe_top rxfe_top_sva #(.FIFO_DEPTH(FIFO_DEPTH)) u_sva (.ref_clk, .sys_rst,
  .hp_addr, .hp_wdata, .hp_wr, .hp_rd, .hp_rdata, .irq, .eeprom_present,
  .eeprom_setup, .rx_valid, .rx_ready, .rx_last, .rx_fcs_bad, .back_to_back,
  .da_pass, .auto_switch_cond, .frame_commit, .frame_drop, .discard_last,
  .dma_mode, .stream_mode);

//--- bench/rxfe_host_model.sv
// Host driver model speaking the register port
`timescale 1ns/1ps
module rxfe_host_model
  import rxfe_pkg::*;
(
  input wire logic ref_clk, // Clock
  output logic [15:0] hp_addr, // Address
  output logic [15:0] hp_wdata, // Write data
  output logic hp_wr, // Write strobe
  output logic hp_rd, // Read strobe
  input wire logic [15:0] hp_rdata // Read data
);
  initial begin
    hp_addr = 16'h0000;
    hp_wdata = 16'h0000;
    hp_wr = 1'b0;
    hp_rd = 1'b0;
  end
  // Released bus shows inverted values so stale data is never mistaken
  task wr_raw(input logic [15:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    hp_addr <= a;
    hp_wdata <= d;
    hp_wr <= 1'b1;
    @(posedge ref_clk);
    hp_wr <= 1'b0;
    hp_addr <= ~a;
    hp_wdata <= ~d;
  endtask
  task wr_setup(input logic [15:0] d);
    logic [15:0] v;
    v = {d[15:6], RXFE_ID_SETUP};
    if (v[RXFE_B_DMA_ALWAYS])
      v[RXFE_B_SKIP] = 1'b0;
    if (!v[RXFE_B_DMA_ALWAYS] && !v[RXFE_B_DMA_AUTO])
      v[RXFE_B_STREAM] = 1'b0;
    wr_raw(RXFE_ADDR_SETUP, v);
  endtask
  task rd(input logic [15:0] a, output logic [15:0] d);
    @(posedge ref_clk);
    hp_addr <= a;
    hp_rd <= 1'b1;
    @(posedge ref_clk);
    hp_rd <= 1'b0;
    hp_addr <= ~a;
    @(negedge ref_clk);
    d = hp_rdata;
  endtask
endmodule

//--- bench/tb.sv
// Self-checking bench for the receive setup and frame event block
`timescale 1ns/1ps
module tb;
  import rxfe_pkg::*;
  logic ref_clk = 1'b0, sys_rst = 1'b1, eeprom_present = 1'b0;
  logic [15:0] hp_addr, hp_wdata, hp_rdata, rv, eeprom_setup = 16'h0000;
  logic hp_wr, hp_rd, irq, rx_ready, buf_valid, rx_valid = 1'b0;
  logic rx_last = 1'b0, rx_fcs_bad = 1'b0, rx_dribble = 1'b0;
  logic [7:0] rx_data = 8'h00, buf_data;
  logic [5:0] da_hash_index = 6'h2d;
  logic da_own = 1'b1, da_bcast = 1'b1, da_hashed = 1'b0, da_pass = 1'b1;
  logic back_to_back = 1'b1, auto_switch_cond = 1'b0, buf_ready = 1'b1;
  logic accept_own_address = 1'b1, accept_all_ones_address = 1'b1;
  logic accept_individual_hash = 1'b1, stall = 1'b0;
  logic frame_commit, frame_drop, discard_last, dma_mode, stream_mode;
  logic [1:0] ph = 2'h0;
  int mismatches = 0, comparisons = 0, stored = 0, skips = 0, base = 0;
  rxfe_top #(.FIFO_DEPTH(RXFE_FIFO_DEPTH)) dut (.ref_clk, .sys_rst, .hp_addr,
    .hp_wdata, .hp_wr, .hp_rd, .hp_rdata, .irq, .eeprom_present,
    .eeprom_setup, .rx_valid, .rx_ready, .rx_data, .rx_last, .rx_fcs_bad,
    .rx_dribble, .da_own, .da_bcast, .da_hashed, .da_hash_index, .da_pass,
    .back_to_back, .auto_switch_cond, .accept_own_address,
    .accept_all_ones_address, .accept_individual_hash, .buf_valid,
    .buf_ready, .buf_data, .frame_commit, .frame_drop, .discard_last,
    .dma_mode, .stream_mode);
  rxfe_host_model host (.ref_clk, .hp_addr, .hp_wdata, .hp_wr, .hp_rd,
    .hp_rdata);
  always #50 ref_clk = ~ref_clk;
  // Drain side stalls one cycle in four so the FIFO sees back-pressure
  always @(posedge ref_clk) begin
    ph <= ph + 2'h1;
    buf_ready <= !stall && ph != 2'h3;
    if (buf_valid && buf_ready) begin
      stored <= stored + 1;
      check("buf", {8'h00, buf_data}, {8'h00, 8'(stored - base)});
    end
    if (discard_last)
      skips <= skips + 1;
  end
  task report_and_stop;
    if (mismatches == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task check(input string name, input logic [15:0] seen,
    input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task rd_chk(input string name, input logic [15:0] a, input logic [15:0] exp);
    host.rd(a, rv);
    check(name, rv, exp);
  endtask
  task send_frame(input int n);
    @(posedge ref_clk);
    for (int i = 0; i < n; i++) begin
      rx_valid <= 1'b1;
      rx_data <= i[7:0];
      rx_last <= (i == n - 1);
      do @(negedge ref_clk); while (rx_ready !== 1'b1);
      @(posedge ref_clk);
    end
    rx_valid <= 1'b0;
    rx_last <= 1'b0;
    rx_data <= ~rx_data;
  endtask
  task frame_case(input int n, input logic [15:0] cfg, input logic [15:0] word,
    input logic irq_exp, input int st_exp);
    int s0;
    host.wr_setup(cfg);
    s0 = stored;
    base = s0;
    send_frame(n);
    @(negedge ref_clk);
    check("irq", {15'h0, irq}, {15'h0, irq_exp});
    rd_chk("event", RXFE_ADDR_EVENT, word);
    rd_chk("event_again", RXFE_ADDR_EVENT, RXFE_EVENT_RST);
    rd_chk("status", RXFE_ADDR_STATUS, word);
    rd_chk("queue", RXFE_ADDR_QUEUE, irq_exp ? word : 16'h0000);
    check("irq_clear", {15'h0, irq}, 16'h0000);
    repeat (12) @(negedge ref_clk);
    if (st_exp >= 0)
      check("stored", 16'(stored - s0), 16'(st_exp));
  endtask
  task t_reset_and_id;
    rd_chk("setup_rst", RXFE_ADDR_SETUP, RXFE_SETUP_RST);
    rd_chk("event_rst", RXFE_ADDR_EVENT, RXFE_EVENT_RST);
    rd_chk("queue_rst", RXFE_ADDR_QUEUE, 16'h0000);
    host.wr_raw(RXFE_ADDR_SETUP, 16'h0100);
    rd_chk("setup_bad_id", RXFE_ADDR_SETUP, RXFE_SETUP_RST);
  endtask
  task t_good_frames;
    frame_case(64, 16'h0100, 16'h0d04, 1'b1, 60);
    rd_chk("len_strip", RXFE_ADDR_LEN, 16'd60);
    @(posedge ref_clk);
    da_own <= 1'b0;
    da_bcast <= 1'b0;
    da_hashed <= 1'b1;
    frame_case(64, 16'h7800, 16'hb744, 1'b0, 64);
    rd_chk("len_keep", RXFE_ADDR_LEN, 16'd64);
  endtask
  task t_bad_frames;
    @(posedge ref_clk);
    rx_fcs_bad <= 1'b1;
    rx_dribble <= 1'b1;
    da_own <= 1'b1;
    da_bcast <= 1'b1;
    frame_case(64, 16'h1800, 16'h1284, 1'b1, -1);
    @(posedge ref_clk);
    rx_dribble <= 1'b0;
    da_hashed <= 1'b0;
    frame_case(64, 16'h0100, 16'h1004, 1'b0, -1);
    @(posedge ref_clk);
    rx_fcs_bad <= 1'b0;
    stall <= 1'b1;
    fork
      begin
        repeat (16) @(negedge ref_clk);
        check("fifo_full", {15'h0, rx_ready}, 16'h0000);
        check("fifo_hold", {15'h0, buf_valid}, 16'h0001);
        stall = 1'b0;
      end
    join_none
    frame_case(20, 16'h2800, 16'h2004, 1'b1, 20);
    @(posedge ref_clk);
    rx_fcs_bad <= 1'b1;
    frame_case(1520, 16'h4800, 16'h5004, 1'b1, 1518);
  endtask
  task t_tiny;
    host.wr_setup(16'h7100);
    base = stored;
    send_frame(7);
    @(negedge ref_clk);
    check("irq_tiny", {15'h0, irq}, 16'h0000);
    rd_chk("event_tiny", RXFE_ADDR_EVENT, RXFE_EVENT_RST);
  endtask
  task t_skip;
    host.wr_setup(16'h0040);
    repeat (3) @(negedge ref_clk);
    check("skips", 16'(skips), 16'h0001);
    rd_chk("setup_skip", RXFE_ADDR_SETUP, RXFE_SETUP_RST);
  endtask
  task t_modes;
    logic [15:0] cfg [5];
    logic [4:0] asw, b2b, pass, dma_exp, strm_exp;
    cfg = '{16'h0280, 16'h0480, 16'h0400, 16'h0680, 16'h0000};
    asw = 5'b10100;
    b2b = 5'b10111;
    pass = 5'b11101;
    dma_exp = 5'b01101;
    strm_exp = 5'b00001;
    for (int i = 0; i < 5; i++) begin
      @(posedge ref_clk);
      auto_switch_cond <= asw[i];
      back_to_back <= b2b[i];
      da_pass <= pass[i];
      host.wr_setup(cfg[i]);
      repeat (2) @(negedge ref_clk);
      check("dma", {15'h0, dma_mode}, {15'h0, dma_exp[i]});
      check("stream", {15'h0, stream_mode}, {15'h0, strm_exp[i]});
      rd_chk("setup_rw", RXFE_ADDR_SETUP, cfg[i] | RXFE_SETUP_RST);
    end
  endtask
  task t_eeprom;
    @(posedge ref_clk);
    sys_rst <= 1'b1;
    eeprom_present <= 1'b1;
    eeprom_setup <= 16'h2a40;
    repeat (3) @(posedge ref_clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rd_chk("setup_eeprom", RXFE_ADDR_SETUP, 16'h2a03);
  endtask
  initial begin
    repeat (3) @(posedge ref_clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    t_reset_and_id;
    t_good_frames;
    t_bad_frames;
    t_tiny;
    t_skip;
    t_modes;
    t_eeprom;
    report_and_stop;
  end
  // Longest frame with stalls needs about 2100 cycles
  initial begin
    repeat (20000) @(posedge ref_clk);
    mismatches++;
    report_and_stop;
  end
endmodule
